// >>> core/geiasc_pkg.sv
package geiasc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Delivery-information field layout
	localparam int unsigned VEC_LSB = 0;
	localparam int unsigned VEC_MSB = 7;
	localparam int unsigned TYPE_LSB = 8;
	localparam int unsigned TYPE_MSB = 10;
	localparam int unsigned ERRV_BIT = 11;
	localparam int unsigned UNDEF_BIT = 12;
	localparam int unsigned RSVD_LSB = 13;
	localparam int unsigned RSVD_MSB = 30;
	localparam int unsigned VALID_BIT = 31;
	// Shadow indicator inside the first header word of a structure region
	localparam int unsigned SHADOW_IND_BIT = 31;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [31:0] RST_WORD32 = 32'h0000_0000;
	localparam logic [63:0] RST_WORD64 = 64'h0000_0000_0000_0000;
	// Link pointer value meaning "no structure named"
	localparam logic [63:0] LINK_NONE = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam logic RST_SHADOW_CTRL = 1'b0;
	// Whether the shadowing execution control can be set to 1
	localparam logic SHADOW_CAPABLE = 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// Instruction-error codes reported by this block
	localparam logic [31:0] ERR_NO_CURRENT = 32'h0000_0001;
	localparam logic [31:0] ERR_RO_FIELD = 32'h0000_0002;
	localparam logic [31:0] ERR_ENTRY_SHADOW = 32'h0000_0003;
	localparam logic [31:0] ERR_LINK_NOT_SHADOW = 32'h0000_0004;
	localparam logic [31:0] ERR_NO_LINK = 32'h0000_0005;

	// Cycles from an accepted field request to its answer
	localparam int unsigned FLD_ANSWER_CYCLES = 1;
	// Saved I/O register store
	localparam int unsigned IO_ENTRIES = 4;
	localparam int unsigned IO_WIDTH = 64;

	typedef enum logic [2:0] {
		EVT_EXT_IRQ = 3'h0,
		EVT_NMI = 3'h2,
		EVT_HW_EXC = 3'h3,
		EVT_SW_IRQ = 3'h4,
		EVT_PRIV_SW_EXC = 3'h5,
		EVT_SW_EXC = 3'h6
	} geiasc_evt_type_t;

	// Field selectors for field_read_op and field_write_op
	typedef enum logic [3:0] {
		FLD_DELIV_INFO = 4'h0,
		FLD_DELIV_ERR = 4'h1,
		FLD_INSTR_LEN = 4'h2,
		FLD_INSTR_INFO = 4'h3,
		FLD_SAVED_COUNT = 4'h4,
		FLD_SAVED_SRC = 4'h5,
		FLD_SAVED_DST = 4'h6,
		FLD_SAVED_IP = 4'h7,
		FLD_INSTR_ERR = 4'h8,
		FLD_SHADOW_CTRL = 4'h9,
		FLD_LINK_PTR = 4'hA
	} geiasc_field_t;

	typedef struct packed {
		logic during_delivery;
		logic [7:0] vector;
		geiasc_evt_type_t evt_type;
		logic err_valid;
		logic [31:0] err_code;
		logic by_instr;
		logic [31:0] instr_len;
		logic info_used;
		logic [31:0] instr_info;
		logic mgmt_after_io;
		logic [63:0] io_count;
		logic [63:0] io_src;
		logic [63:0] io_dst;
		logic [63:0] io_ip;
	} geiasc_exit_rec_t;

	typedef struct packed {
		logic wr;
		logic guest;
		geiasc_field_t sel;
		logic [63:0] wdata;
	} geiasc_fld_req_t;

endpackage : geiasc_pkg

// >>> core/geiasc_info_enc.sv
`timescale 1ns/10ps
module geiasc_info_enc (
	input wire geiasc_pkg::geiasc_exit_rec_t rec,
	output logic [31:0] info
);

	always_comb begin
		info = geiasc_pkg::RST_WORD32;
		info[geiasc_pkg::VEC_MSB:geiasc_pkg::VEC_LSB] = rec.vector;
		info[geiasc_pkg::TYPE_MSB:geiasc_pkg::TYPE_LSB] = rec.evt_type;
		info[geiasc_pkg::ERRV_BIT] = rec.err_valid;
		// bit 12 undefined, driven low
		info[geiasc_pkg::UNDEF_BIT] = 1'b0;
		info[geiasc_pkg::RSVD_MSB:geiasc_pkg::RSVD_LSB] = 18'h0_0000;
		info[geiasc_pkg::VALID_BIT] = rec.during_delivery;
	end

endmodule : geiasc_info_enc

// >>> core/geiasc_io_store.sv
`timescale 1ns/10ps
module geiasc_io_store (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic wr_en,
	input wire logic [geiasc_pkg::IO_ENTRIES*geiasc_pkg::IO_WIDTH-1:0] wr_data,
	input wire logic [1:0] rd_idx,
	output logic [geiasc_pkg::IO_WIDTH-1:0] rd_data
);

	logic [geiasc_pkg::IO_WIDTH-1:0] mem [geiasc_pkg::IO_ENTRIES];

	// All entries are written together by one exit
	genvar g;
	generate
		for (g = 0; g < geiasc_pkg::IO_ENTRIES; g++) begin : g_entry
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					mem[g] <= geiasc_pkg::RST_WORD64;
				end else if (wr_en) begin
					mem[g] <= wr_data[g*geiasc_pkg::IO_WIDTH +: geiasc_pkg::IO_WIDTH];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= geiasc_pkg::RST_WORD64;
		end else begin
			rd_data <= mem[rd_idx];
		end
	end

endmodule : geiasc_io_store

// >>> core/geiasc_top.sv
`timescale 1ns/10ps
//
// Contract
// - Delivery info bits 7:0 hold vector
// - Bits 10:8 hold delivered event type
// - Bit 11 flags valid error code
// - Bits 30:13 zero; bit 12 undefined
// - Bit 31 set when exit interrupts delivery
// - Store hardware exception error code
// - Store exiting instruction length
// - Store instruction information for listed exits
// - Save count/source/dest on post-I/O interrupt
// - Save I/O instruction pointer likewise
// - Instruction error unchanged by exits
// - Header bit 31 selects shadow type
// - Shadow support needs shadowing control capability
// - Guest entry fails on shadow current
// - Shadowing 0: guest field ops exit
// - Shadowing 1: guest ops use link
// - Shadowing 1: entry checks link is shadow
// - Host ops allowed on both types
module geiasc_top (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic exit_valid,
	input wire geiasc_pkg::geiasc_exit_rec_t exit_rec,
	input wire logic vi_err_valid,
	input wire logic [31:0] vi_err_code,
	input wire logic make_current,
	input wire logic [31:0] cur_hdr,
	input wire logic deactivate,
	input wire logic link_hdr_ld,
	input wire logic [31:0] link_hdr,
	input wire logic entry_req,
	input wire logic fld_req_valid,
	input wire geiasc_pkg::geiasc_fld_req_t fld_req,
	output logic fld_busy,
	output logic fld_ack,
	output logic fld_fail,
	output logic fld_exit,
	output logic fld_link_acc,
	output logic [63:0] fld_rdata,
	output logic entry_ok,
	output logic entry_fail,
	output logic cur_valid,
	output logic cur_is_shadow,
	output logic shadow_ctrl_eff
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RESP = 2'b10
	} geiasc_state_t;

	geiasc_state_t state;
	geiasc_state_t next_state;
	geiasc_pkg::geiasc_fld_req_t req_q;

	logic [31:0] deliv_info;
	logic [31:0] deliv_err;
	logic [31:0] instr_len;
	logic [31:0] instr_info;
	logic [31:0] instr_err;
	logic shadow_ctrl;
	logic [63:0] link_ptr;
	logic link_is_shadow;
	logic [31:0] next_info;
	logic [63:0] io_rdata;
	logic [1:0] io_idx;
	logic link_named;
	logic req_ro;
	logic req_io;

	// Outcome of the registered request, decided in ST_RESP
	logic do_exit;
	logic do_link;
	logic do_fail;
	logic do_write;
	logic [31:0] fail_code;
	logic [63:0] read_word;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	geiasc_info_enc u_info_enc (
		.rec(exit_rec),
		.info(next_info)
	);

	// Read index follows the incoming request so data is ready at ST_RESP
	assign io_idx = fld_req.sel[1:0];

	geiasc_io_store u_io_store (
		.clk(clk),
		.arst_n(arst_n),
		// only on post-I/O mgmt interrupt exits
		.wr_en(exit_valid && exit_rec.mgmt_after_io),
		.wr_data({exit_rec.io_ip, exit_rec.io_dst, exit_rec.io_src, exit_rec.io_count}),
		.rd_idx(io_idx),
		.rd_data(io_rdata)
	);

	logic shadow_ctrl_eff_c;
	assign shadow_ctrl_eff_c = shadow_ctrl && geiasc_pkg::SHADOW_CAPABLE;

	assign link_named = (link_ptr != geiasc_pkg::LINK_NONE);

	////////////////////////////////////////////////////////////////////////////
	// Exit information capture

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			deliv_info <= geiasc_pkg::RST_WORD32;
		end else if (exit_valid) begin
			// stale record cleared by non-delivery exit
			deliv_info <= next_info;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			deliv_err <= geiasc_pkg::RST_WORD32;
		end else if (exit_valid && exit_rec.during_delivery && exit_rec.err_valid &&
			exit_rec.evt_type == geiasc_pkg::EVT_HW_EXC) begin
			deliv_err <= exit_rec.err_code;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			instr_len <= geiasc_pkg::RST_WORD32;
		end else if (exit_valid && exit_rec.by_instr) begin
			instr_len <= exit_rec.instr_len;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			instr_info <= geiasc_pkg::RST_WORD32;
		end else if (exit_valid && exit_rec.info_used) begin
			instr_info <= exit_rec.instr_info;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Current and link structure type

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_valid <= 1'b0;
			cur_is_shadow <= 1'b0;
		end else if (make_current) begin
			cur_valid <= 1'b1;
			cur_is_shadow <= cur_hdr[geiasc_pkg::SHADOW_IND_BIT] && geiasc_pkg::SHADOW_CAPABLE;
		end else if (deactivate) begin
			cur_valid <= 1'b0;
			cur_is_shadow <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			link_is_shadow <= 1'b0;
		end else if (link_hdr_ld) begin
			// same indicator for the linked structure
			link_is_shadow <= link_hdr[geiasc_pkg::SHADOW_IND_BIT] && geiasc_pkg::SHADOW_CAPABLE;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			shadow_ctrl_eff <= 1'b0;
		end else begin
			shadow_ctrl_eff <= shadow_ctrl_eff_c;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Guest entry checks

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			entry_ok <= 1'b0;
			entry_fail <= 1'b0;
		end else begin
			entry_ok <= 1'b0;
			entry_fail <= 1'b0;
			if (entry_req) begin
				if (!cur_valid || cur_is_shadow) begin
					entry_fail <= 1'b1;
				end else if (shadow_ctrl_eff_c && link_named && !link_is_shadow) begin
					entry_fail <= 1'b1;
				end else begin
					entry_ok <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Field access sequencing

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (fld_req_valid) begin
					next_state = ST_RESP;
				end
			end
			ST_RESP: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			req_q <= '0;
		end else if (state == ST_IDLE && fld_req_valid) begin
			req_q <= fld_req;
		end
	end

	// Requests are refused while busy rather than queued
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fld_busy <= 1'b0;
		end else begin
			fld_busy <= (next_state == ST_RESP);
		end
	end

	assign req_io = (req_q.sel == geiasc_pkg::FLD_SAVED_COUNT) ||
		(req_q.sel == geiasc_pkg::FLD_SAVED_SRC) ||
		(req_q.sel == geiasc_pkg::FLD_SAVED_DST) ||
		(req_q.sel == geiasc_pkg::FLD_SAVED_IP);
	assign req_ro = (req_q.sel != geiasc_pkg::FLD_SHADOW_CTRL) &&
		(req_q.sel != geiasc_pkg::FLD_LINK_PTR);

	always_comb begin
		do_exit = 1'b0;
		do_link = 1'b0;
		do_fail = 1'b0;
		do_write = 1'b0;
		fail_code = geiasc_pkg::RST_WORD32;
		if (req_q.guest) begin
			if (!shadow_ctrl_eff_c) begin
				do_exit = 1'b1;
			end else if (link_named) begin
				do_link = 1'b1;
			end else begin
				do_fail = 1'b1;
				fail_code = geiasc_pkg::ERR_NO_LINK;
			end
		end else if (!cur_valid) begin
			do_fail = 1'b1;
			fail_code = geiasc_pkg::ERR_NO_CURRENT;
		end else if (req_q.wr && req_ro) begin
			do_fail = 1'b1;
			fail_code = geiasc_pkg::ERR_RO_FIELD;
		end else if (req_q.wr) begin
			do_write = 1'b1;
		end
	end

	// Address decode of the read data
	always_comb begin
		read_word = geiasc_pkg::RST_WORD64;
		if (req_io) begin
			read_word = io_rdata;
		end else if (req_q.sel == geiasc_pkg::FLD_DELIV_INFO) begin
			read_word = {32'h0000_0000, deliv_info};
		end else if (req_q.sel == geiasc_pkg::FLD_DELIV_ERR) begin
			read_word = {32'h0000_0000, deliv_err};
		end else if (req_q.sel == geiasc_pkg::FLD_INSTR_LEN) begin
			read_word = {32'h0000_0000, instr_len};
		end else if (req_q.sel == geiasc_pkg::FLD_INSTR_INFO) begin
			read_word = {32'h0000_0000, instr_info};
		end else if (req_q.sel == geiasc_pkg::FLD_INSTR_ERR) begin
			read_word = {32'h0000_0000, instr_err};
		end else if (req_q.sel == geiasc_pkg::FLD_SHADOW_CTRL) begin
			read_word = {63'h0, shadow_ctrl};
		end else if (req_q.sel == geiasc_pkg::FLD_LINK_PTR) begin
			read_word = link_ptr;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fld_ack <= 1'b0;
			fld_fail <= 1'b0;
			fld_exit <= 1'b0;
			fld_link_acc <= 1'b0;
			fld_rdata <= geiasc_pkg::RST_WORD64;
		end else begin
			fld_ack <= 1'b0;
			fld_fail <= 1'b0;
			fld_exit <= 1'b0;
			fld_link_acc <= 1'b0;
			if (state == ST_RESP) begin
				fld_exit <= do_exit;
				fld_link_acc <= do_link;
				fld_fail <= do_fail;
				fld_ack <= !do_exit && !do_link && !do_fail;
				if (!req_q.wr && !do_exit && !do_link && !do_fail) begin
					fld_rdata <= read_word;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Writable controls and instruction error

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			shadow_ctrl <= geiasc_pkg::RST_SHADOW_CTRL;
			link_ptr <= geiasc_pkg::LINK_NONE;
		end else if (state == ST_RESP && do_write) begin
			if (req_q.sel == geiasc_pkg::FLD_SHADOW_CTRL) begin
				// Incapable parts keep the control at 0
				shadow_ctrl <= req_q.wdata[0] && geiasc_pkg::SHADOW_CAPABLE;
			end else if (req_q.sel == geiasc_pkg::FLD_LINK_PTR) begin
				link_ptr <= req_q.wdata;
			end
		end
	end

	// Exits never touch this field; only failed non-faulting ops do
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			instr_err <= geiasc_pkg::RST_WORD32;
		end else if (state == ST_RESP && do_fail) begin
			instr_err <= fail_code;
		end else if (entry_req && cur_valid && cur_is_shadow) begin
			instr_err <= geiasc_pkg::ERR_ENTRY_SHADOW;
		end else if (entry_req && cur_valid && shadow_ctrl_eff_c && link_named &&
			!link_is_shadow) begin
			instr_err <= geiasc_pkg::ERR_LINK_NOT_SHADOW;
		end else if (vi_err_valid) begin
			instr_err <= vi_err_code;
		end
	end

endmodule : geiasc_top

// >>> test/geiasc_top_chk.sv
`timescale 1ns/10ps
module geiasc_top_chk (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic make_current,
	input wire logic [31:0] cur_hdr,
	input wire logic entry_req,
	input wire logic fld_req_valid,
	input wire geiasc_pkg::geiasc_fld_req_t fld_req,
	input wire logic fld_busy,
	input wire logic fld_ack,
	input wire logic fld_fail,
	input wire logic fld_exit,
	input wire logic fld_link_acc,
	input wire logic [63:0] fld_rdata,
	input wire logic entry_ok,
	input wire logic entry_fail,
	input wire logic cur_valid,
	input wire logic cur_is_shadow,
	input wire logic shadow_ctrl_eff
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	logic taken;
	logic hrd;
	assign taken = fld_req_valid && !fld_busy;
	assign hrd = taken && !fld_req.guest && !fld_req.wr;
	////////////////////////////////////////////////////////////////////////////
	// Control and current state are looked at one cycle after taking,
	// where the response logic reads them
	AST_ONE_ANSWER: assert property (
		taken |-> ##2 $onehot({fld_ack, fld_fail, fld_exit, fld_link_acc}))
		else $error("field access without single answer");
	AST_BUSY_PULSE: assert property (
		taken |=> fld_busy ##1 !fld_busy)
		else $error("busy not one response cycle");
	AST_GUEST_EXIT: assert property (
		taken && fld_req.guest ##1 !shadow_ctrl_eff |=> fld_exit)
		else $error("guest op without exit");
	AST_GUEST_LINK: assert property (
		taken && fld_req.guest ##1 shadow_ctrl_eff |=> (fld_link_acc || fld_fail))
		else $error("guest op not sent to link");
	AST_HOST_READ: assert property (
		hrd ##1 cur_valid |=> fld_ack)
		else $error("host read refused");
	AST_RSVD_ZERO: assert property (
		hrd && fld_req.sel == geiasc_pkg::FLD_DELIV_INFO ##1 cur_valid |=>
			fld_rdata[30:13] == 18'h0)
		else $error("reserved delivery bits set");
	AST_RDATA_HOLD: assert property (
		$changed(fld_rdata) |-> fld_ack)
		else $error("read data moved without ack");
	AST_CUR_TYPE: assert property (
		make_current |=> cur_valid && cur_is_shadow == $past(cur_hdr[31]))
		else $error("structure type not from header");
	AST_ENTRY_SHADOW: assert property (
		entry_req && cur_valid && cur_is_shadow && !make_current |=> entry_fail && !entry_ok)
		else $error("entry on shadow accepted");
endmodule : geiasc_top_chk

bind geiasc_top geiasc_top_chk u_geiasc_top_chk (.clk, .arst_n, .make_current, .cur_hdr,
	.entry_req, .fld_req_valid, .fld_req, .fld_busy, .fld_ack, .fld_fail, .fld_exit,
	.fld_link_acc, .fld_rdata, .entry_ok, .entry_fail, .cur_valid, .cur_is_shadow,
	.shadow_ctrl_eff);

// >>> test/geiasc_top_tb_top.sv
`timescale 1ns/10ps
module geiasc_top_tb_top;
	localparam logic [63:0] ACK = 64'h8;
	localparam logic [63:0] FAIL = 64'h4;
	localparam logic [63:0] EXT = 64'h2;
	localparam logic [63:0] LNK = 64'h1;
	localparam logic [63:0] IOB = 64'hF0F0_0000_0000_0A00;
	logic clk, arst_n, exit_valid, vi_err_valid, make_current, deactivate;
	logic link_hdr_ld, entry_req, fld_req_valid;
	geiasc_pkg::geiasc_exit_rec_t exit_rec;
	geiasc_pkg::geiasc_fld_req_t fld_req;
	logic [31:0] vi_err_code, cur_hdr, link_hdr;
	logic fld_busy, fld_ack, fld_fail, fld_exit, fld_link_acc;
	logic entry_ok, entry_fail, cur_valid, cur_is_shadow, shadow_ctrl_eff;
	logic [63:0] fld_rdata, resp, rd, di;
	logic [1:0] ent;
	logic [2:0] ty [6];
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;

	geiasc_top u_geiasc_top (.clk, .arst_n, .exit_valid, .exit_rec, .vi_err_valid,
		.vi_err_code, .make_current, .cur_hdr, .deactivate, .link_hdr_ld, .link_hdr,
		.entry_req, .fld_req_valid, .fld_req, .fld_busy, .fld_ack, .fld_fail, .fld_exit,
		.fld_link_acc, .fld_rdata, .entry_ok, .entry_fail, .cur_valid, .cur_is_shadow,
		.shadow_ctrl_eff);

	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Hang guard, far above the roughly 180 cycles the tests use
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			end_of_test;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic step;
		@(posedge clk);
		#10;
	endtask : step

	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Answer is fixed at one cycle, so a request never meets busy here
	task automatic fld(input logic wr, input logic guest, input logic [3:0] sel,
		input logic [63:0] wd);
		fld_req = {wr, guest, sel, wd};
		fld_req_valid = 1'b1;
		step;
		fld_req_valid = 1'b0;
		step;
		resp = {60'h0, fld_ack, fld_fail, fld_exit, fld_link_acc};
		rd = fld_rdata;
	endtask : fld

	task automatic rdchk(input string what, input logic [3:0] sel, input logic [63:0] exp);
		fld(1'b0, 1'b0, sel, 64'h0);
		chk(what, resp, ACK);
		chk(what, rd, exp);
	endtask : rdchk

	// Entry answer stands one cycle only: caught before lowering the pulse
	task automatic pulse(ref logic s);
		s = 1'b1;
		step;
		ent = {entry_ok, entry_fail};
		s = 1'b0;
		step;
	endtask : pulse

	task automatic iox(input logic on, input logic [63:0] b);
		exit_rec = '0;
		exit_rec.by_instr = on;
		exit_rec.instr_len = b[31:0];
		exit_rec.info_used = on;
		exit_rec.instr_info = ~b[31:0];
		exit_rec.mgmt_after_io = on;
		exit_rec.io_count = b | 64'h4;
		exit_rec.io_src = b | 64'h5;
		exit_rec.io_dst = b | 64'h6;
		exit_rec.io_ip = b | 64'h7;
		pulse(exit_valid);
		rdchk("valid clear", 4'h0, 64'h0);
		rdchk("instr len", 4'h2, {32'h0, IOB[31:0]});
		rdchk("instr info", 4'h3, {32'h0, ~IOB[31:0]});
		for (int i = 4; i < 8; i++) begin
			rdchk("saved io", i[3:0], IOB | 64'(i));
		end
	endtask : iox

	task automatic end_of_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////////
	initial begin
		arst_n = 1'b0;
		{exit_valid, vi_err_valid, make_current, deactivate} = 4'h0;
		{link_hdr_ld, entry_req, fld_req_valid} = 3'h0;
		exit_rec = '0;
		fld_req = '0;
		vi_err_code = 32'h0;
		cur_hdr = 32'h0000_0001;
		link_hdr = 32'h0;
		ty = '{3'h3, 3'h0, 3'h2, 3'h4, 3'h5, 3'h6};
		repeat (12) @(posedge clk);
		#10;
		arst_n = 1'b1;
		step;
		pulse(make_current);
		chk("ordinary", {62'h0, cur_valid, cur_is_shadow}, 64'h2);
		for (int i = 0; i < 9; i++) begin
			rdchk("field reset", i[3:0], 64'h0);
		end
		rdchk("link reset", 4'hA, 64'hFFFF_FFFF_FFFF_FFFF);
		$display("test reset done");
		// Type 3 first: later types must leave its error code alone
		for (int i = 0; i < 6; i++) begin
			exit_rec = '0;
			exit_rec.during_delivery = 1'b1;
			exit_rec.vector = 8'hE0 + 8'(i);
			exit_rec.evt_type = geiasc_pkg::geiasc_evt_type_t'(ty[i]);
			exit_rec.err_valid = ~i[0];
			exit_rec.err_code = 32'hC0DE_0000 + 32'(i);
			pulse(exit_valid);
			di = {32'h0, 1'b1, 19'h0, ~i[0], ty[i], 8'hE0 + 8'(i)};
			rdchk("deliv info", 4'h0, di);
			rdchk("deliv err", 4'h1, 64'hC0DE_0000);
		end
		$display("test delivery done");
		iox(1'b1, IOB);
		iox(1'b0, ~IOB);
		$display("test instr exit done");
		for (int i = 0; i < 9; i++) begin
			fld(1'b1, 1'b0, i[3:0], 64'h0);
			chk("ro write", resp, FAIL);
		end
		rdchk("err ro", 4'h8, 64'h2);
		vi_err_code = 32'h0000_0077;
		pulse(vi_err_valid);
		rdchk("err vi", 4'h8, 64'h77);
		iox(1'b1, IOB);
		rdchk("err kept", 4'h8, 64'h77);
		$display("test instr error done");
		fld(1'b0, 1'b1, 4'h0, 64'h0);
		chk("guest exit", resp, EXT);
		fld(1'b1, 1'b0, 4'h9, 64'h1);
		chk("ctrl write", resp, ACK);
		step;
		chk("ctrl eff", {63'h0, shadow_ctrl_eff}, 64'h1);
		fld(1'b0, 1'b1, 4'h0, 64'h0);
		chk("no link", resp, FAIL);
		rdchk("err link", 4'h8, 64'h5);
		fld(1'b1, 1'b0, 4'hA, 64'h2000);
		chk("link write", resp, ACK);
		rdchk("link ptr", 4'hA, 64'h2000);
		fld(1'b0, 1'b1, 4'h0, 64'h0);
		chk("link acc", resp, LNK);
		pulse(link_hdr_ld);
		pulse(entry_req);
		chk("link ordinary", {62'h0, ent}, 64'h1);
		rdchk("err entry", 4'h8, 64'h4);
		link_hdr = 32'h8000_0000;
		pulse(link_hdr_ld);
		pulse(entry_req);
		chk("link shadow", {62'h0, ent}, 64'h2);
		// Type bit only changes on an inactive structure
		pulse(deactivate);
		cur_hdr = 32'h8000_0000;
		pulse(make_current);
		chk("shadow cur", {63'h0, cur_is_shadow}, 64'h1);
		pulse(entry_req);
		chk("shadow entry", {62'h0, ent}, 64'h1);
		rdchk("err shadow", 4'h8, 64'h3);
		pulse(deactivate);
		fld(1'b0, 1'b0, 4'h8, 64'h0);
		chk("no current", resp, FAIL);
		$display("test shadow done");
		end_of_test;
	end
endmodule : geiasc_top_tb_top
